// File: pkg/roc_cfg.svh
// register offsets, field positions, reset values and decode constants
// assumes inclusion by the register bank module; the package does not include it
`ifndef ROC_CFG_SVH
`define ROC_CFG_SVH

// register offsets
`define ROC_ADDR_STATUS 8'h00
`define ROC_ADDR_SET2 8'h02
`define ROC_ADDR_LEVEL 8'h03
`define ROC_ADDR_CMD 8'h04

// status fields
`define ROC_ST_FLAGS_HI 7
`define ROC_ST_FLAGS_LO 5
`define ROC_ST_ENS 3
`define ROC_ST_ONE 2
`define ROC_ST_NOFAULT 1
`define ROC_ST_PGS 0

// second settings register fields
`define ROC_S2_MRG_HI 3
`define ROC_S2_MRG_LO 2
`define ROC_MRG_NONE 2'h0
`define ROC_MRG_LOWER 2'h1

// command fields
`define ROC_CMD_CLEAR 0

// reset values
`define ROC_FLAGS_RST 3'h0
`define ROC_BYTE_ZERO 8'h00
`define ROC_DEF_LEVEL 8'h52
`define ROC_DEF_SET2 7'h00
`define ROC_S2_MASK 7'h7f

// level code ranges as codes; bases, steps and tops in millivolts
`define ROC_R1_LAST 8'h80
`define ROC_R2_FIRST 8'h81
`define ROC_R2_LAST 8'hc3
`define ROC_R3_FIRST 8'hc4
`define ROC_R3_LAST 8'hf4
`define ROC_R4_FIRST 8'hf5
`define ROC_R1_BASE 13'h0280
`define ROC_R2_BASE 13'h050a
`define ROC_R3_BASE 13'h07bc
`define ROC_R4_BASE 13'h128e
`define ROC_R1_STEP 13'h0005
`define ROC_R2_STEP 13'h000a
`define ROC_R3_STEP 13'h001e
`define ROC_R4_STEP 13'h0032
`define ROC_R1_TOP 13'h0500
`define ROC_R2_TOP 13'h079e
`define ROC_R3_TOP 13'h0d5c
`define ROC_R4_TOP 13'h1482

`endif

// File: pkg/roc_pkg.sv
// types shared by the regulator output and command register bank
// assumes roc_cfg.svh is on the include path
`default_nettype none
package roc_pkg;
   typedef struct packed {
      logic [2:0] flags;
      logic [7:0] level;
      logic [6:0] set2;
      logic clr;
      logic [12:0] target_mv;
      logic [7:0] rdata;
      logic rvalid;
   } roc_state_t;
endpackage
`default_nettype wire

// File: hdl/roc_regs.sv
// output level code, second settings and command registers of a buck regulator
// assumes a serial front end that hands over byte reads and writes on clk
//
// Summary of operation
// - level code writable anytime, host steps slowly
// - codes 00-80 from 640 mV, 5 mV steps
// - codes 81-c3 from 1290 mV, 10 mV steps
// - codes c4-f4 from 1980 mV, 30 mV steps
// - codes f5-ff from 4750 mV, 50 mV steps
// - reset reloads factory defaults, writes are volatile
// - upper command bits ignored, read zero
// - command bit zero clears all fault flags except those raised again in the clearing cycle
// - clear bit returns to zero by itself
// - fault flags latch until clear or reset
// - margin field: none, minus five, plus five
`include "roc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module roc_regs #(
   parameter logic [7:0] DEF_LEVEL = `ROC_DEF_LEVEL,
   parameter logic [6:0] DEF_SET2 = `ROC_DEF_SET2
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // byte register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // device pins and fault events, order over-current, shutdown, warning
   input wire logic en_pin,
   input wire logic pg_pin,
   input wire logic [2:0] fault_in,
   // regulator control
   output logic [7:0] output_level_bits,
   output logic [12:0] target_mv,
   output logic margin_lower,
   output logic margin_raise,
   output logic [6:0] setting2_bits
);
   logic rst_meta_r;
   logic rst_sync_n_r;
   roc_pkg::roc_state_t s_r;
   roc_pkg::roc_state_t s_nxt;
   logic wr_level;
   logic wr_set2;
   logic wr_clear;

   function automatic logic [12:0] decode(input logic [7:0] c);
      logic [12:0] cw;
      cw = {5'h00, c};
      if (c <= `ROC_R1_LAST)
         decode = 13'(`ROC_R1_BASE + `ROC_R1_STEP * cw);
      else if (c <= `ROC_R2_LAST)
         decode = 13'(`ROC_R2_BASE + `ROC_R2_STEP * (cw - {5'h00, `ROC_R2_FIRST}));
      else if (c <= `ROC_R3_LAST)
         decode = 13'(`ROC_R3_BASE + `ROC_R3_STEP * (cw - {5'h00, `ROC_R3_FIRST}));
      else
         decode = 13'(`ROC_R4_BASE + `ROC_R4_STEP * (cw - {5'h00, `ROC_R4_FIRST}));
   endfunction

   // factory target worked out once, so the reset branch loads a constant
   localparam logic [12:0] DEF_MV = decode(DEF_LEVEL);

   // reset released through two flops, asserted at once
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_n_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_n_r <= rst_meta_r;
      end
   end

   assign wr_level = reg_wr && (reg_addr == `ROC_ADDR_LEVEL);
   assign wr_set2 = reg_wr && (reg_addr == `ROC_ADDR_SET2);
   assign wr_clear = reg_wr && (reg_addr == `ROC_ADDR_CMD) && reg_wdata[`ROC_CMD_CLEAR];

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rvalid = reg_rd;
      // no lockout while delivering: pacing and range keeping are the host's job
      if (wr_level)
         s_nxt.level = reg_wdata;
      if (wr_set2)
         s_nxt.set2 = reg_wdata[6:0];
      // only bit zero is kept; the rest of a command write is dropped
      s_nxt.clr = wr_clear;
      // a fault arriving in the clearing cycle survives the clear
      if (s_r.clr)
         s_nxt.flags = fault_in;
      else
         s_nxt.flags = s_r.flags | fault_in;
      // one cycle behind the code register, no host action needed
      s_nxt.target_mv = decode(s_r.level);
      if (reg_rd)
      begin
         unique case (reg_addr)
            `ROC_ADDR_STATUS: s_nxt.rdata = {s_r.flags, 1'b0, en_pin, 1'b1,
                                              ~|s_r.flags, pg_pin};
            `ROC_ADDR_SET2: s_nxt.rdata = {1'b0, s_r.set2};
            `ROC_ADDR_LEVEL: s_nxt.rdata = s_r.level;
            `ROC_ADDR_CMD: s_nxt.rdata = {7'h00, s_r.clr};
            default: s_nxt.rdata = `ROC_BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_sync_n_r)
   begin
      if (!rst_sync_n_r)
      begin
         // factory values come back on every power cycle
         s_r.flags <= `ROC_FLAGS_RST;
         s_r.level <= DEF_LEVEL;
         s_r.set2 <= DEF_SET2;
         s_r.clr <= 1'b0;
         s_r.target_mv <= DEF_MV;
         s_r.rdata <= `ROC_BYTE_ZERO;
         s_r.rvalid <= 1'b0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign reg_rvalid = s_r.rvalid;
   assign output_level_bits = s_r.level;
   assign target_mv = s_r.target_mv;
   assign setting2_bits = s_r.set2;
   assign margin_lower = (s_r.set2[`ROC_S2_MRG_HI:`ROC_S2_MRG_LO] == `ROC_MRG_LOWER);
   assign margin_raise = s_r.set2[`ROC_S2_MRG_HI];

   a_flag_held: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (!s_r.clr && (s_r.flags != 3'h0)) |=> ((s_r.flags & $past(s_r.flags)) == $past(s_r.flags)))
      else $error("fault flag dropped without clear");
   a_clear_cmd: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      wr_clear |=> s_r.clr ##1 (s_r.flags == $past(fault_in)))
      else $error("flags not cleared after clear command");
   a_clear_self: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (s_r.clr && !wr_clear) |=> !s_r.clr)
      else $error("clear bit did not return to zero");
   a_cmd_upper: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (reg_rd && reg_addr == `ROC_ADDR_CMD) |=> (reg_rdata[7:1] == 7'h00) && reg_rvalid)
      else $error("upper command bits not zero");
   a_level_apply: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (wr_level && !$past(wr_level)) |=> (output_level_bits == $past(reg_wdata))
      ##1 (target_mv == decode($past(reg_wdata, 2))))
      else $error("level code not applied after write");
   a_range_one: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      $stable(s_r.level) && s_r.level <= `ROC_R1_LAST |=>
      target_mv >= `ROC_R1_BASE && target_mv <= `ROC_R1_TOP && (target_mv % 5) == 0)
      else $error("first range decode wrong");
   a_range_two: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      $stable(s_r.level) && s_r.level >= `ROC_R2_FIRST && s_r.level <= `ROC_R2_LAST |=>
      target_mv >= `ROC_R2_BASE && target_mv <= `ROC_R2_TOP && (target_mv % 10) == 0)
      else $error("second range decode wrong");
   a_range_three: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      $stable(s_r.level) && s_r.level >= `ROC_R3_FIRST && s_r.level <= `ROC_R3_LAST |=>
      target_mv >= `ROC_R3_BASE && target_mv <= `ROC_R3_TOP
      && ((target_mv - `ROC_R3_BASE) % 30) == 0)
      else $error("third range decode wrong");
   a_range_four: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      $stable(s_r.level) && s_r.level >= `ROC_R4_FIRST |=>
      target_mv >= `ROC_R4_BASE && target_mv <= `ROC_R4_TOP
      && ((target_mv - `ROC_R4_BASE) % 50) == 0)
      else $error("fourth range decode wrong");
   a_reset_defaults: assert property (@(posedge clk)
      $rose(rst_sync_n_r) |-> (output_level_bits == DEF_LEVEL) && (s_r.flags == 3'h0)
      && (setting2_bits == DEF_SET2)
      && (target_mv == DEF_MV))
      else $error("factory defaults not loaded");
   a_margin_map: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (wr_set2 && reg_wdata[3:2] == 2'h1) |=> margin_lower && !margin_raise)
      else $error("margin lower decode wrong");

   // both upper patterns raise, never lower
   a_margin_up: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (wr_set2 && reg_wdata[`ROC_S2_MRG_HI]) |=> margin_raise && !margin_lower)
      else $error("margin raise decode wrong");

   // zero pattern leaves the nominal level alone
   a_margin_none: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (wr_set2 && reg_wdata[`ROC_S2_MRG_HI:`ROC_S2_MRG_LO] == `ROC_MRG_NONE) |=>
      !margin_raise && !margin_lower)
      else $error("margin none decode wrong");

   // a fault seen at any edge shows next cycle, clearing or not
   a_fault_latch: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (fault_in != `ROC_FLAGS_RST) |=> ((s_r.flags & $past(fault_in)) == $past(fault_in)))
      else $error("fault event not latched");

   // clear drops every flag that was not raised again in that cycle
   a_clear_flags: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      s_r.clr |=> ((s_r.flags & ~$past(fault_in)) == `ROC_FLAGS_RST))
      else $error("flag survived the clear");

   // command write without the clear bit must change nothing
   a_cmd_inert: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (reg_wr && reg_addr == `ROC_ADDR_CMD && !reg_wdata[`ROC_CMD_CLEAR]) |=>
      !s_r.clr && ((s_r.flags & $past(s_r.flags)) == $past(s_r.flags))
      && $stable(output_level_bits) && $stable(setting2_bits))
      else $error("upper command bits had an effect");

   // status read returns the latched flags and the fixed one bit
   a_status_read: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      (reg_rd && reg_addr == `ROC_ADDR_STATUS) |=>
      (reg_rdata[`ROC_ST_FLAGS_HI:`ROC_ST_FLAGS_LO] == $past(s_r.flags))
      && reg_rdata[`ROC_ST_ONE] && (reg_rdata[`ROC_ST_NOFAULT] == ~|$past(s_r.flags)))
      else $error("status read wrong");

   // level code only moves on its own write
   a_level_keep: assert property (@(posedge clk) disable iff (!rst_sync_n_r)
      !wr_level |=> $stable(output_level_bits))
      else $error("level code changed without write");
endmodule
`default_nettype wire

// File: test/roc_host_model.sv
// host model driving the byte register port and the enable pin
// assumes the bench calls its tasks 1 ns after a rising clk edge
`timescale 1ns/100ps
`default_nettype none
module roc_host_model (
   // clock
   input wire logic clk,
   // register port and enable pin
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic en_pin
);
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      en_pin = 1'h1;
   end
   // released lines show the inverse so stale values never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'h1;
      @(posedge clk);
      #1;
      reg_wr = 1'h0;
      reg_addr = ~a;
      reg_wdata = ~d;
      // idle edge, so a following call never re-raises the strobe in this step
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr = a;
      reg_rd = 1'h1;
      @(posedge clk);
      #1;
      reg_rd = 1'h0;
      reg_addr = ~a;
      @(posedge clk);
      #1;
   endtask
   task automatic set_en(input logic v);
      en_pin = v;
   endtask
   // upward single steps; caller keeps both ends in one range
   task automatic step_level(input logic [7:0] lo, input logic [7:0] hi);
      for (logic [8:0] c = {1'h0, lo}; c <= {1'h0, hi}; c++)
         wr(8'h03, c[7:0]);
   endtask
   task automatic reconfig(input logic [7:0] d);
      en_pin = 1'h0;
      wr(8'h02, d);
      en_pin = 1'h1;
   endtask
endmodule
`default_nettype wire

// File: test/regulator_output_command_regs_tb_top.sv
// self-checking bench for the level code and command register bank
// assumes roc_regs and roc_host_model are compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin fail_count++; \
   $display("mismatch %s expected %h seen %h", n, e, a); end end
module regulator_output_command_regs_tb_top;
   logic clk = 1'h0, rstn = 1'h0, pg_pin = 1'h1;
   logic [2:0] fault_in = 3'h0;
   wire logic [7:0] reg_addr, reg_wdata;
   wire logic reg_wr, reg_rd, en_pin;
   logic [7:0] reg_rdata, output_level_bits, exp_r;
   logic reg_rvalid, margin_lower, margin_raise;
   logic [12:0] target_mv;
   logic [6:0] setting2_bits;
   int fail_count, compares, cyc;
   logic [7:0] q[$];
   logic [16:0] rnd = 17'h13a69;
   logic [7:0] codes [8] = '{8'h00, 8'h80, 8'h81, 8'hc3, 8'hc4, 8'hf4, 8'hf5, 8'hff};
   logic [7:0] c;
   roc_host_model h (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .en_pin(en_pin));
   roc_regs i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .en_pin(en_pin), .pg_pin(pg_pin), .fault_in(fault_in),
      .output_level_bits(output_level_bits), .target_mv(target_mv),
      .margin_lower(margin_lower), .margin_raise(margin_raise),
      .setting2_bits(setting2_bits));
   function automatic logic [12:0] mv(input logic [7:0] k);
      if (k <= 8'h80) return 13'h0280 + 13'(k) * 13'h0005;
      if (k <= 8'hc3) return 13'h050a + 13'(k - 8'h81) * 13'h000a;
      if (k <= 8'hf4) return 13'h07bc + 13'(k - 8'hc4) * 13'h001e;
      return 13'h128e + 13'(k - 8'hf5) * 13'h0032;
   endfunction
   function automatic logic [16:0] lfsr(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      q.push_back(e);
      h.rd(a);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic complete_run;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
      forever #2 clk = ~clk;
   // mid-cycle, so the registered answer has settled
   always @(negedge clk)
   begin
      cyc++;
      if (reg_rvalid === 1'h1)
      begin
         exp_r = q.pop_front();
         `CHK("rdata", exp_r, reg_rdata)
      end
      if (cyc == 3000)
      begin
         fail_count++;
         complete_run();
      end
   end
   initial
   begin
      tick(8);
      rstn = 1'h1;
      tick(3);
      rdc(8'h03, 8'h52);
      rdc(8'h04, 8'h00);
      rdc(8'h00, 8'h0f);
      `CHK("target", mv(8'h52), target_mv)
      h.set_en(1'h0);
      for (int i = 0; i < 12; i++)
      begin
         c = (i < 8) ? codes[i] : rnd[7:0];
         rnd = lfsr(rnd);
         h.wr(8'h03, c);
         tick(2);
         `CHK("level", c, output_level_bits)
         `CHK("target", mv(c), target_mv)
      end
      h.wr(8'h03, 8'h10);
      h.set_en(1'h1);
      h.step_level(8'h11, 8'h14);
      tick(2);
      `CHK("step", mv(8'h14), target_mv)
      h.reconfig(8'h8d);
      rdc(8'h02, 8'h0d);
      for (int m = 0; m < 4; m++)
      begin
         h.wr(8'h02, {4'h0, 2'(m), 2'h1});
         tick(1);
         `CHK("lower", (m == 1), margin_lower)
         `CHK("raise", (m >= 2), margin_raise)
      end
      fault_in = 3'h5;
      tick(1);
      fault_in = 3'h0;
      tick(2);
      rdc(8'h00, 8'had);
      h.wr(8'h04, 8'hfe);
      tick(2);
      rdc(8'h00, 8'had);
      h.wr(8'h04, 8'hff);
      tick(3);
      rdc(8'h00, 8'h0f);
      rdc(8'h04, 8'h00);
      h.wr(8'h03, 8'h20);
      rstn = 1'h0;
      tick(2);
      rstn = 1'h1;
      tick(3);
      rdc(8'h03, 8'h52);
      tick(3);
      complete_run();
   end
endmodule
`default_nettype wire
